// [design/sbd_pkg.sv]
// Purpose: Shared constants and types for the passive SPI bus decoder.
// Assumes: Analyser clock of 10 MHz; bus lines sampled asynchronously.
// Notes: Configuration travels as one packed struct.
package sbd_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_WORD_BITS = 32;
  localparam int WORD_LEN_W = 6;
  localparam int BIT_CNT_W = 16;
  localparam int IDLE_W = 16;
  localparam int IDLE_TIME_NS = 10_000;
  localparam logic [IDLE_W-1:0] IDLE_CYCLES_DEFAULT =
    IDLE_W'((IDLE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam logic [WORD_LEN_W-1:0] WORD_LEN_RESET = 6'h08;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    TRIG_FRAME_START,
    TRIG_FRAME_END,
    TRIG_BIT,
    TRIG_PATTERN
  } sbd_trig_mode_t;

  typedef enum logic [1:0] {
    INST_1,
    INST_2,
    INST_3,
    INST_4
  } sbd_inst_t;

  typedef struct packed {
    logic useCs;
    logic sampleFalling;
    logic csActiveHigh;
    logic mosiActiveHigh;
    logic misoActiveHigh;
    logic misoEnable;
    logic lsbFirst;
    logic [WORD_LEN_W-1:0] wordLen;
    logic [IDLE_W-1:0] idleCycles;
    sbd_trig_mode_t trigMode;
    logic trigOnMiso;
    logic [BIT_CNT_W-1:0] bitOffset;
    logic [5:0] patLen;
    logic [MAX_WORD_BITS-1:0] patData;
    logic [MAX_WORD_BITS-1:0] patCare;
  } sbd_cfg_t;

  typedef struct packed {
    logic [MAX_WORD_BITS-1:0] mosi;
    logic [MAX_WORD_BITS-1:0] miso;
    logic misoValid;
  } sbd_word_t;

  typedef struct packed {
    logic [BIT_CNT_W-1:0] wordCount;
    logic partialError;
  } sbd_frame_t;

  // Reset defaults: chip select reads active low, data lines active high.
  localparam logic CS_ACTIVE_HIGH_RESET = 1'b0;
  localparam logic DATA_ACTIVE_HIGH_RESET = 1'b1;

endpackage : sbd_pkg

// [design/sbd_spi_bus_decoder.sv]
// Purpose: Passive SPI monitor that groups bits into words and frames.
// Assumes: Bus pins are asynchronous to clock and are synchronised here.
// Notes: Pin edges are found by sampling, so the bus clock must be slow.
module sbd_spi_bus_decoder
  import sbd_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Monitored bus pins.
  input wire logic busClk,
  input wire logic busCs,
  input wire logic busMosi,
  input wire logic busMiso,
  // Configuration.
  input wire sbd_cfg_t cfg,
  input wire logic cfgLoad,
  input wire sbd_inst_t busNum,
  // Decoded results.
  output sbd_word_t word,
  output logic wordValid,
  output sbd_frame_t frame,
  output logic frameValid,
  output logic frameStart,
  output logic trigger,
  output logic misoGranted,
  output logic pairConsumed,
  output sbd_cfg_t cfgActive
);

  logic [SYNC_STAGES-1:0] syncClk, syncCs, syncMosi, syncMiso;
  logic clkD, csD, inFrame, next_inFrame;
  logic [MAX_WORD_BITS-1:0] shMosi, shMiso, next_shMosi, next_shMiso;
  logic [WORD_LEN_W-1:0] bitInWord, next_bitInWord;
  logic [BIT_CNT_W-1:0] bitCount, next_bitCount;
  logic [BIT_CNT_W-1:0] wordCount, next_wordCount;
  logic [IDLE_W-1:0] idleCnt, next_idleCnt;
  logic [MAX_WORD_BITS-1:0] patShift, next_patShift;
  logic [5:0] patFill, next_patFill;
  logic patDone, next_patDone;
  sbd_cfg_t next_cfgActive;
  sbd_word_t next_word;
  sbd_frame_t next_frame;
  logic next_wordValid, next_frameValid, next_frameStart, next_trigger;
  logic next_misoGranted, next_pairConsumed;

  // Two-stage synchronisers; only the last stage is read by logic.
  always_ff @(posedge clock) begin
    if (rst) begin
      syncClk <= '0;
      syncCs <= '1;
      syncMosi <= '0;
      syncMiso <= '0;
    end else begin
      syncClk <= {syncClk[0], busClk};
      syncCs <= {syncCs[0], busCs};
      syncMosi <= {syncMosi[0], busMosi};
      syncMiso <= {syncMiso[0], busMiso};
    end
  end

  logic clkS, csS, mosiBit, misoBit, misoOk, csActive, sampleEdge;
  logic csRise, csFall, useCs, idleExpired, lastBit;
  logic [WORD_LEN_W-1:0] wlen;
  logic trigBitA;

  always_comb begin
    clkS = syncClk[1];
    csS = syncCs[1];
    // Polarity folds each line into logic one per its setting.
    mosiBit = cfgActive.mosiActiveHigh ? syncMosi[1] : ~syncMosi[1];
    misoBit = cfgActive.misoActiveHigh ? syncMiso[1] : ~syncMiso[1];
    csActive = cfgActive.csActiveHigh ? csS : ~csS;
    useCs = cfgActive.useCs;
    // Both edges of the chip select are seen through the line polarity.
    csRise = useCs & csActive & ~(cfgActive.csActiveHigh ? csD : ~csD);
    csFall = useCs & ~csActive & (cfgActive.csActiveHigh ? csD : ~csD);
    sampleEdge = cfgActive.sampleFalling ? (clkD & ~clkS)
                                         : (~clkD & clkS);
    misoOk = cfgActive.misoEnable & misoGranted;
    // Word length is clamped to 1..32 bits.
    if (cfgActive.wordLen == '0) begin
      wlen = 6'h01;
    end else if (cfgActive.wordLen > 6'(MAX_WORD_BITS)) begin
      wlen = 6'(MAX_WORD_BITS);
    end else begin
      wlen = cfgActive.wordLen;
    end
    lastBit = (bitInWord == wlen - 6'h01);
    idleExpired = ~useCs & inFrame & (idleCnt >= cfgActive.idleCycles);
    trigBitA = (bitCount == cfgActive.bitOffset);
  end

  always_comb begin
    next_cfgActive = cfgLoad ? cfg : cfgActive;
    next_misoGranted = (busNum == INST_1) | (busNum == INST_3);
    next_pairConsumed = cfgActive.misoEnable & next_misoGranted;
    next_inFrame = inFrame;
    next_shMosi = shMosi;
    next_shMiso = shMiso;
    next_bitInWord = bitInWord;
    next_bitCount = bitCount;
    next_wordCount = wordCount;
    next_idleCnt = idleCnt;
    next_patShift = patShift;
    next_patFill = patFill;
    next_patDone = patDone;
    next_word = word;
    next_frame = frame;
    next_wordValid = 1'b0;
    next_frameValid = 1'b0;
    next_frameStart = 1'b0;
    next_trigger = 1'b0;

    if (useCs) begin
      next_idleCnt = '0;
    end else if (sampleEdge) begin
      next_idleCnt = '0;
    end else if (inFrame && idleCnt != '1) begin
      next_idleCnt = idleCnt + IDLE_W'(1);
    end

    // Frame closes on chip select release or idle expiry.
    if ((useCs && csFall && inFrame) || idleExpired) begin
      next_inFrame = 1'b0;
      next_bitInWord = '0;
      next_frame.wordCount = wordCount;
      next_frame.partialError = (bitInWord != '0);
      next_frameValid = (wordCount != '0);
      if (cfgActive.trigMode == TRIG_FRAME_END) begin
        next_trigger = (wordCount != '0);
      end
    end else if (useCs && csRise) begin
      next_inFrame = 1'b1;
      next_bitInWord = '0;
      next_bitCount = '0;
      next_wordCount = '0;
      next_patFill = '0;
      next_patDone = 1'b0;
      next_frameStart = 1'b1;
      next_trigger = (cfgActive.trigMode == TRIG_FRAME_START);
    end else if (sampleEdge && (inFrame || !useCs)) begin
      if (!inFrame) begin
        // First edge after idle opens a new frame.
        next_inFrame = 1'b1;
        next_bitCount = '0;
        next_wordCount = '0;
        next_patFill = '0;
        next_patDone = 1'b0;
        next_frameStart = 1'b1;
        next_trigger = (cfgActive.trigMode == TRIG_FRAME_START);
      end
      // MOSI and MISO are shifted on the same edge.
      if (cfgActive.lsbFirst) begin
        next_shMosi = shMosi | (MAX_WORD_BITS'(mosiBit) << bitInWord);
        next_shMiso = shMiso | (MAX_WORD_BITS'(misoBit) << bitInWord);
      end else begin
        next_shMosi = {shMosi[MAX_WORD_BITS-2:0], mosiBit};
        next_shMiso = {shMiso[MAX_WORD_BITS-2:0], misoBit};
      end
      if (bitInWord == '0) begin
        next_shMosi = cfgActive.lsbFirst ? MAX_WORD_BITS'(mosiBit)
                                         : MAX_WORD_BITS'(mosiBit);
        next_shMiso = MAX_WORD_BITS'(misoBit);
      end
      if (inFrame && trigBitA && cfgActive.trigMode == TRIG_BIT) begin
        next_trigger = 1'b1;
      end else if (!inFrame && cfgActive.bitOffset == '0 &&
                   cfgActive.trigMode == TRIG_BIT) begin
        next_trigger = 1'b1;
      end
      next_bitCount = (inFrame ? bitCount : '0) + BIT_CNT_W'(1);
      // Pattern window starts after the offset bits.
      if ((inFrame ? bitCount : '0) >= cfgActive.bitOffset && !patDone
          && patFill < cfgActive.patLen) begin
        next_patShift = {patShift[MAX_WORD_BITS-2:0],
                         (cfgActive.trigOnMiso && misoOk) ? misoBit
                                                          : mosiBit};
        next_patFill = patFill + 6'h01;
        if (patFill + 6'h01 == cfgActive.patLen) begin
          next_patDone = 1'b1;
          if (cfgActive.trigMode == TRIG_PATTERN &&
              ((({next_patShift} ^ cfgActive.patData) &
                cfgActive.patCare) == '0)) begin
            next_trigger = 1'b1;
          end
        end
      end
      if (lastBit) begin
        next_bitInWord = '0;
        next_word.mosi = next_shMosi;
        next_word.miso = misoOk ? next_shMiso : '0;
        next_word.misoValid = misoOk;
        next_wordValid = 1'b1;
        next_wordCount = (inFrame ? wordCount : '0) + BIT_CNT_W'(1);
      end else begin
        next_bitInWord = (inFrame ? bitInWord : '0) + 6'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      clkD <= 1'b0;
      csD <= 1'b1;
      inFrame <= 1'b0;
      shMosi <= '0;
      shMiso <= '0;
      bitInWord <= '0;
      bitCount <= '0;
      wordCount <= '0;
      idleCnt <= '0;
      patShift <= '0;
      patFill <= '0;
      patDone <= 1'b0;
      word <= '0;
      frame <= '0;
      wordValid <= 1'b0;
      frameValid <= 1'b0;
      frameStart <= 1'b0;
      trigger <= 1'b0;
      misoGranted <= 1'b0;
      pairConsumed <= 1'b0;
      cfgActive <= '{useCs: 1'b1, sampleFalling: 1'b0,
                     csActiveHigh: CS_ACTIVE_HIGH_RESET,
                     mosiActiveHigh: DATA_ACTIVE_HIGH_RESET,
                     misoActiveHigh: DATA_ACTIVE_HIGH_RESET,
                     misoEnable: 1'b0, lsbFirst: 1'b0,
                     wordLen: WORD_LEN_RESET,
                     idleCycles: IDLE_CYCLES_DEFAULT,
                     trigMode: TRIG_FRAME_START, trigOnMiso: 1'b0,
                     bitOffset: '0, patLen: '0, patData: '0,
                     patCare: '0};
    end else begin
      clkD <= clkS;
      csD <= csS;
      inFrame <= next_inFrame;
      shMosi <= next_shMosi;
      shMiso <= next_shMiso;
      bitInWord <= next_bitInWord;
      bitCount <= next_bitCount;
      wordCount <= next_wordCount;
      idleCnt <= next_idleCnt;
      patShift <= next_patShift;
      patFill <= next_patFill;
      patDone <= next_patDone;
      word <= next_word;
      frame <= next_frame;
      wordValid <= next_wordValid;
      frameValid <= next_frameValid;
      frameStart <= next_frameStart;
      trigger <= next_trigger;
      misoGranted <= next_misoGranted;
      pairConsumed <= next_pairConsumed;
      cfgActive <= next_cfgActive;
    end
  end

endmodule : sbd_spi_bus_decoder

// [tb/sbd_decoder_properties.sv]
// Purpose: Port-level timing and reset checks for the bus decoder.
// Assumes: One clock domain with a synchronous reset.
// Notes: Attached to every decoder by the bind below.
module sbd_decoder_properties
  import sbd_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Observed ports.
  input wire logic busCs,
  input wire sbd_cfg_t cfg,
  input wire logic cfgLoad,
  input wire sbd_inst_t busNum,
  input wire logic wordValid,
  input wire sbd_frame_t frame,
  input wire logic frameValid,
  input wire logic frameStart,
  input wire logic misoGranted,
  input wire logic pairConsumed,
  input wire sbd_cfg_t cfgActive
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Chip select seen going active under the reset polarity.
  sequence csOpens;
    cfgActive.useCs && !cfgActive.csActiveHigh && $fell(busCs);
  endsequence
  cs_reset_a: assert property ($fell(rst) |-> !cfgActive.csActiveHigh)
    else $error("chip select polarity wrong after reset");
  data_reset_a: assert property ($fell(rst) |->
    cfgActive.mosiActiveHigh && cfgActive.misoActiveHigh)
    else $error("data polarity wrong after reset");
  cfg_load_a: assert property (cfgLoad |=> cfgActive == $past(cfg))
    else $error("configuration not taken");
  cfg_hold_a: assert property (!cfgLoad |=> $stable(cfgActive))
    else $error("configuration changed without load");
  miso_grant_a: assert property (1'b1 |=> misoGranted ==
    ($past(busNum) == INST_1 || $past(busNum) == INST_3))
    else $error("miso grant does not follow instance");
  pair_free_a: assert property (!cfgActive.misoEnable [*3] |->
    !pairConsumed)
    else $error("pair consumed without miso");
  frame_open_a: assert property (csOpens |-> ##[2:5] frameStart)
    else $error("no frame start after chip select");
  frame_words_a: assert property (frameValid |->
    frame.wordCount != 16'h0)
    else $error("empty frame reported");
  word_pulse_a: assert property (wordValid |=> !wordValid)
    else $error("word pulse longer than one cycle");
endmodule : sbd_decoder_properties

bind sbd_spi_bus_decoder sbd_decoder_properties u_props (.clock, .rst,
  .busCs, .cfg, .cfgLoad, .busNum, .wordValid, .frame, .frameValid,
  .frameStart, .misoGranted, .pairConsumed, .cfgActive);

// [tb/sbd_spi_bus_decoder_tb.sv]
// Purpose: Self-checking bench for the bus decoder.
// Assumes: Master model drives the pins; 10 MHz clock.
// Notes: Inputs change on the falling edge of clock.
module sbd_spi_bus_decoder_tb
  import sbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic busClk, busCs, busMosi, busMiso;
  sbd_cfg_t cfg, cfgActive, base;
  logic cfgLoad = 1'b0;
  sbd_inst_t busNum = INST_1;
  sbd_word_t word;
  sbd_frame_t frame;
  logic wordValid, frameValid, frameStart, trigger;
  logic misoGranted, pairConsumed;
  int n_mismatch = 0;
  int cmp_count = 0;
  int nTrig = 0;
  bit seen;
  always #50 clock = ~clock;
  always @(negedge clock) nTrig += (trigger === 1'b1);
  sbd_spi_bus_decoder DUT (.clock, .rst, .busClk, .busCs, .busMosi,
    .busMiso, .cfg, .cfgLoad, .busNum, .word, .wordValid, .frame,
    .frameValid, .frameStart, .trigger, .misoGranted, .pairConsumed,
    .cfgActive);
  sbd_spi_master_model bfm (.busClk, .busCs, .busMosi, .busMiso);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic load(input sbd_cfg_t c);
    cfg = c;
    cfgLoad = 1'b1;
    @(negedge clock);
    cfgLoad = 1'b0;
  endtask : load
  task automatic waitFrame();
    seen = 1'b0;
    for (int k = 0; k < 80 && !seen; k++) begin
      @(negedge clock);
      seen = (frameValid === 1'b1);
    end
  endtask : waitFrame
  task automatic t_reset();
    chk({cfgActive.useCs, cfgActive.csActiveHigh}, 2'h2);
    chk({cfgActive.mosiActiveHigh, cfgActive.misoActiveHigh}, 2'h3);
    chk(cfgActive.wordLen, WORD_LEN_RESET);
  endtask : t_reset
  task automatic t_duplex();
    load(base);
    bfm.frame(32'ha5, 32'h3c, 8, 1'b0, 1'b0);
    waitFrame();
    chk(seen, 1'b1);
    chk(word.mosi, 32'ha5);
    chk(word.miso, 32'h3c);
    chk({frame.wordCount, frame.partialError}, 17'h2);
    chk(pairConsumed, 1'b1);
  endtask : t_duplex
  task automatic t_partial();
    bfm.frame(32'habc, 32'h0, 12, 1'b0, 1'b0);
    waitFrame();
    chk(word.mosi, 32'hab);
    chk({frame.wordCount, frame.partialError}, 17'h3);
    bfm.frame(32'h5, 32'h0, 3, 1'b0, 1'b0);
    waitFrame();
    chk(seen, 1'b0);
  endtask : t_partial
  task automatic t_nocs();
    sbd_cfg_t c;
    c = base;
    c.useCs = 1'b0;
    load(c);
    // The gap between these two words is shorter than the idle time.
    bfm.frame(32'h12, 32'h0, 8, 1'b1, 1'b0);
    bfm.frame(32'h34, 32'h0, 8, 1'b1, 1'b0);
    waitFrame();
    chk(word.mosi, 32'h34);
    chk(frame.wordCount, 16'h2);
  endtask : t_nocs
  task automatic t_trig();
    sbd_cfg_t c;
    int t0;
    c = base;
    c.bitOffset = 16'h2;
    c.patLen = 6'h04;
    c.patData = 32'h9;
    c.patCare = 32'hf;
    for (int m = 0; m < 4; m++) begin
      c.trigMode = sbd_trig_mode_t'(m);
      load(c);
      t0 = nTrig;
      bfm.frame(32'ha5, 32'h0, 8, 1'b0, 1'b0);
      waitFrame();
      @(negedge clock);
      chk(nTrig - t0, 32'h1);
    end
    // One cared bit differs from the sent bits, so no trigger may fire.
    c.trigMode = TRIG_PATTERN;
    c.patData = 32'h8;
    load(c);
    t0 = nTrig;
    bfm.frame(32'ha5, 32'h0, 8, 1'b0, 1'b0);
    waitFrame();
    @(negedge clock);
    chk(nTrig - t0, 32'h0);
  endtask : t_trig
  task automatic t_order_pol();
    sbd_cfg_t c;
    c = base;
    c.lsbFirst = 1'b1;
    c.sampleFalling = 1'b1;
    c.csActiveHigh = 1'b1;
    c.mosiActiveHigh = 1'b0;
    c.wordLen = 6'h05;
    busNum = INST_2;
    load(c);
    bfm.frame(32'h0b, 32'h1f, 5, 1'b1, 1'b1);
    waitFrame();
    chk(word.mosi[4:0], 5'h05);
    chk(word.miso, 32'h0);
    chk({misoGranted, pairConsumed}, 2'h0);
  endtask : t_order_pol
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  initial begin
    base = '0;
    base.useCs = 1'b1;
    base.mosiActiveHigh = 1'b1;
    base.misoActiveHigh = 1'b1;
    base.misoEnable = 1'b1;
    base.wordLen = 6'h08;
    base.idleCycles = 16'h001e;
    cfg = base;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    t_reset();
    t_duplex();
    t_partial();
    t_nocs();
    t_trig();
    t_order_pol();
    conclude();
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    conclude();
  end
endmodule : sbd_spi_bus_decoder_tb

// [tb/sbd_spi_master_model.sv]
// Purpose: Behavioural bus master driving the monitored pins.
// Assumes: Bus clock idles low, 800 ns period.
// Notes: Called at a falling edge of the system clock.
module sbd_spi_master_model (
  // Monitored bus pins.
  output logic busClk,
  output logic busCs,
  output logic busMosi,
  output logic busMiso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    busClk = 1'b0;
    busCs = 1'b1;
    busMosi = 1'b0;
    busMiso = 1'b0;
  end
  // Sends n bits, most significant first; no address, no acknowledge.
  // Data moves on the edge opposite the sampled one, so it stays settled
  // across the edge that the decoder picks when fall says which one.
  task automatic frame(input logic [31:0] mo, input logic [31:0] mi,
    input int n, input logic csOn, input logic fall);
    busCs = ~csOn;
    #400 busCs = csOn;
    for (int i = n - 1; i >= 0; i--) begin
      if (!fall) begin
        busMosi = mo[i];
        busMiso = mi[i];
      end
      #400 busClk = 1'b1;
      if (fall) begin
        busMosi = mo[i];
        busMiso = mi[i];
      end
      #400 busClk = 1'b0;
    end
    #400 busCs = ~csOn;
    // Released lines must not keep showing the last bit.
    busMosi = ~busMosi;
    busMiso = ~busMiso;
  endtask : frame
endmodule : sbd_spi_master_model
